// [rtl/watchdog_control_status.sv]
// Summary of operation
// RULE1: response select set gives interrupt on timeout (here forced codes reset regardless)
// RULE2: response select clear gives system reset
// RULE3: period codes: timed, auto reset, download, invalid
// RULE4: timeout always sets status flag
// RULE5: status cleared by writing zero or pin reset
// RULE6: watchdog reset leaves status flag intact
// RULE7: writing enable one starts and zeroes counter
// RULE8: each further enable write services the counter
// RULE9: unserviced timeout gives reset or interrupt
// RULE10: disable on zero, reset, pin, supply, lock (here pin reset loads enable one)
// RULE11: reset values: enable one, others zero
// RULE12: control write needs unlock in previous instruction
// RULE13: firmware masks interrupts around unlock sequence
// RULE14: unlock lapses after the following instruction
`default_nettype none

module watchdog_control_status #(
    parameter int BASE_CYCLES = wdt_pkg::BASE_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       instr_done,
    input  wire logic       supply_monitor_event,
    input  wire logic       lock_loss_event,
    output logic      [7:0] sfr_rdata,
    output logic            wdt_irq,
    output logic            wdt_reset,
    output logic            download_reset
);

    wdt_tick_if tick ();

    wdt_timer #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (tick)
    );

    logic [3:0] period_q;
    logic [3:0] period_d;
    logic       rsp_sel_q;
    logic       rsp_sel_d;
    logic       status_q;
    logic       status_d;
    logic       enable_q;
    logic       enable_d;
    logic       unlock_q;
    logic       unlock_d;
    logic [1:0] age_q;
    logic [1:0] age_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       irq_q;
    logic       irq_d;
    logic       rst_q;
    logic       rst_d;
    logic       dl_q;
    logic       dl_d;

    logic       ctrl_wr;
    logic       accept_wr;
    logic       timeout;
    logic       timed_code;
    logic       forced_code;

    always_comb begin
        ctrl_wr     = sfr_wr && (sfr_addr == wdt_pkg::WDOG_CTRL_ADDR);
        accept_wr   = ctrl_wr && unlock_q
                      && (age_q == wdt_pkg::AGE_WINDOW); // see RULE12
        timed_code  = period_q <= wdt_pkg::PERIOD_MAX_TIMED; // see RULE3
        forced_code = (period_q == wdt_pkg::PERIOD_AUTO_RST)
                      || (period_q == wdt_pkg::PERIOD_DL_RST); // see RULE3
        // invalid codes never time out
        timeout     = enable_q
                      && ((timed_code && tick.expire) || forced_code);

        tick.run    = enable_q && timed_code;
        tick.period = period_q[2:0];
        tick.clear  = accept_wr && sfr_wdata[wdt_pkg::ENABLE_BIT]; // see RULE7 RULE8

        period_d  = period_q;
        rsp_sel_d = rsp_sel_q;
        status_d  = status_q;
        enable_d  = enable_q;
        unlock_d  = unlock_q;
        age_d     = age_q;

        if (accept_wr) begin
            period_d  = sfr_wdata[wdt_pkg::PERIOD_MSB:wdt_pkg::PERIOD_LSB];
            rsp_sel_d = sfr_wdata[wdt_pkg::RSP_SEL_BIT];
            enable_d  = sfr_wdata[wdt_pkg::ENABLE_BIT]; // see RULE7 RULE10
            if (!sfr_wdata[wdt_pkg::STATUS_BIT]) begin
                status_d = 1'b0; // see RULE5
            end
            unlock_d  = 1'b0; // see RULE14
        end else if (ctrl_wr && sfr_wdata[wdt_pkg::UNLOCK_BIT]) begin
            // locked writes may only raise the unlock bit
            unlock_d = 1'b1; // see RULE12
            age_d    = wdt_pkg::AGE_SET;
        end else if (unlock_q && instr_done) begin
            if (age_q == wdt_pkg::AGE_WINDOW) begin
                unlock_d = 1'b0; // see RULE14
            end else begin
                age_d = wdt_pkg::AGE_WINDOW;
            end
        end

        if (timeout) begin
            status_d = 1'b1; // see RULE4 RULE6
            if (!rsp_sel_q || forced_code) begin
                enable_d = 1'b0; // see RULE10
            end
        end
        if (supply_monitor_event || lock_loss_event) begin
            enable_d = 1'b0; // see RULE10
        end
    end

    always_comb begin
        // interrupt only for timed codes, forced codes always reset
        irq_d = timeout && rsp_sel_q && !forced_code; // see RULE1 RULE9
        rst_d = timeout && (!rsp_sel_q || forced_code); // see RULE2 RULE9
        dl_d  = timeout && (period_q == wdt_pkg::PERIOD_DL_RST); // see RULE3
        rdata_d = {period_d, rsp_sel_d, status_d, enable_d, unlock_d};
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // pin reset is the only reset this block sees
            period_q  <= wdt_pkg::PERIOD_RST;
            rsp_sel_q <= wdt_pkg::RSP_SEL_RST; // see RULE11
            status_q  <= wdt_pkg::STATUS_RST;  // see RULE5 RULE11
            enable_q  <= wdt_pkg::ENABLE_RST;  // see RULE10 RULE11
            unlock_q  <= wdt_pkg::UNLOCK_RST;  // see RULE11
            age_q     <= wdt_pkg::AGE_SET;
            rdata_q   <= {wdt_pkg::PERIOD_RST, wdt_pkg::RSP_SEL_RST,
                          wdt_pkg::STATUS_RST, wdt_pkg::ENABLE_RST,
                          wdt_pkg::UNLOCK_RST};
            irq_q     <= 1'b0;
            rst_q     <= 1'b0;
            dl_q      <= 1'b0;
        end else begin
            period_q  <= period_d;
            rsp_sel_q <= rsp_sel_d;
            status_q  <= status_d;
            enable_q  <= enable_d;
            unlock_q  <= unlock_d;
            age_q     <= age_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
            rst_q     <= rst_d;
            dl_q      <= dl_d;
        end
    end

    assign sfr_rdata      = rdata_q;
    assign wdt_irq        = irq_q;
    assign wdt_reset      = rst_q;
    assign download_reset = dl_q;

endmodule : watchdog_control_status

`default_nettype wire

// [rtl/wdt_pkg.sv]
`default_nettype none

package wdt_pkg;

    localparam logic [7:0] WDOG_CTRL_ADDR = 8'hc0;

    // field positions of watchdog_control
    localparam int PERIOD_MSB   = 7;
    localparam int PERIOD_LSB   = 4;
    localparam int RSP_SEL_BIT  = 3;
    localparam int STATUS_BIT   = 2;
    localparam int ENABLE_BIT   = 1;
    localparam int UNLOCK_BIT   = 0;

    localparam logic [3:0] PERIOD_RST  = 4'h0;
    localparam logic       RSP_SEL_RST = 1'b0;
    localparam logic       STATUS_RST  = 1'b0;
    localparam logic       ENABLE_RST  = 1'b1;
    localparam logic       UNLOCK_RST  = 1'b0;

    // period codes
    localparam logic [3:0] PERIOD_MAX_TIMED = 4'h7;
    localparam logic [3:0] PERIOD_AUTO_RST  = 4'h8;
    localparam logic [3:0] PERIOD_DL_RST    = 4'h9;

    // shortest timeout, doubled per code step
    localparam int BASE_TIMEOUT_NS = 15625000;
    localparam int CLK_PERIOD_NS   = 5;
    localparam int BASE_CYCLES     = BASE_TIMEOUT_NS / CLK_PERIOD_NS;

    localparam int DIV_W  = 22;
    localparam int TICK_W = 8;

    // instructions ended since the unlock bit was set
    localparam logic [1:0] AGE_SET    = 2'h0;
    localparam logic [1:0] AGE_WINDOW = 2'h1;

endpackage : wdt_pkg

`default_nettype wire

// [rtl/wdt_tick_if.sv]
`default_nettype none

interface wdt_tick_if;
    logic       run;
    logic       clear;
    logic [2:0] period;
    logic       expire;

    modport ctrl  (output run, output clear, output period, input expire);
    modport timer (input run, input clear, input period, output expire);
endinterface : wdt_tick_if

`default_nettype wire

// [rtl/wdt_timer.sv]
`default_nettype none

module wdt_timer #(
    parameter int BASE_CYCLES = wdt_pkg::BASE_CYCLES
) (
    input  wire logic   sys_clk,
    input  wire logic   arst_n,
    wdt_tick_if.timer   tick
);

    localparam logic [wdt_pkg::DIV_W-1:0] DIV_LAST =
        wdt_pkg::DIV_W'(BASE_CYCLES - 1);

    logic [wdt_pkg::DIV_W-1:0]  div_q;
    logic [wdt_pkg::DIV_W-1:0]  div_d;
    logic [wdt_pkg::TICK_W-1:0] ticks_q;
    logic [wdt_pkg::TICK_W-1:0] ticks_d;
    logic                       expire_q;
    logic                       expire_d;
    logic [wdt_pkg::TICK_W-1:0] limit;

    always_comb begin
        limit    = wdt_pkg::TICK_W'(1) << tick.period;
        div_d    = div_q;
        ticks_d  = ticks_q;
        expire_d = 1'b0;
        if (tick.clear || !tick.run) begin
            div_d   = '0;
            ticks_d = '0;
        end else if (div_q == DIV_LAST) begin
            div_d = '0;
            if (ticks_q + 1'b1 == limit) begin
                // restart so an interrupt response repeats each period
                ticks_d  = '0;
                expire_d = 1'b1;
            end else begin
                ticks_d = ticks_q + 1'b1;
            end
        end else begin
            div_d = div_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q    <= '0;
            ticks_q  <= '0;
            expire_q <= 1'b0;
        end else begin
            div_q    <= div_d;
            ticks_q  <= ticks_d;
            expire_q <= expire_d;
        end
    end

    assign tick.expire = expire_q;

endmodule : wdt_timer

`default_nettype wire

// [verif/watchdog_control_status_assertions.sv]
`default_nettype none
module watchdog_control_status_assertions #(
    parameter int BASE_CYCLES = 8
) (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic       supply_monitor_event,
    input wire logic       lock_loss_event,
    input wire logic [7:0] sfr_rdata,
    input wire logic       wdt_irq,
    input wire logic       wdt_reset,
    input wire logic       download_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_rv; $rose(arst_n) |-> sfr_rdata == 8'h02; endproperty
    a_rv: assert property (p_rv) else $error("reset value");
    property p_rs; wdt_reset |-> ##2 sfr_rdata[2:1] == 2'b10; endproperty
    a_rs: assert property (p_rs) else $error("reset status");
    property p_is; wdt_irq |-> ##2 sfr_rdata[2]; endproperty
    a_is: assert property (p_is) else $error("irq status");
    property p_ex; wdt_irq |-> !wdt_reset; endproperty
    a_ex: assert property (p_ex) else $error("irq and reset");
    property p_dl; download_reset |-> wdt_reset; endproperty
    a_dl: assert property (p_dl) else $error("download alone");
    property p_pl; (wdt_irq || wdt_reset) |=> !(wdt_irq || wdt_reset);
    endproperty
    a_pl: assert property (p_pl) else $error("long pulse");
    property p_lk; (sfr_wr && sfr_addr == 8'hc0 && !sfr_rdata[0])
        |-> ##2 sfr_rdata[7:3] == $past(sfr_rdata[7:3], 2); endproperty
    a_lk: assert property (p_lk) else $error("locked write");
    property p_ev; (supply_monitor_event || lock_loss_event)
        |-> ##2 !sfr_rdata[1]; endproperty
    a_ev: assert property (p_ev) else $error("event enable");
    property p_st; $fell(sfr_rdata[2]) |-> $past(sfr_wr) || $past(sfr_wr, 2);
    endproperty
    a_st: assert property (p_st) else $error("status fell");
    c_irq: cover property (wdt_irq);
    c_dl: cover property (download_reset);
    c_ev: cover property (lock_loss_event);
endmodule : watchdog_control_status_assertions

bind watchdog_control_status watchdog_control_status_assertions #(
    .BASE_CYCLES(BASE_CYCLES)) u_wdt_chk (.sys_clk(sys_clk),
    .arst_n(arst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .supply_monitor_event(supply_monitor_event),
    .lock_loss_event(lock_loss_event), .sfr_rdata(sfr_rdata),
    .wdt_irq(wdt_irq), .wdt_reset(wdt_reset),
    .download_reset(download_reset));
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk, arst_n, sfr_wr, instr_done, wdt_irq;
    logic       supply_monitor_event, lock_loss_event, wdt_reset;
    logic       download_reset;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0] p;
    int         n_mismatch, compares, n_irq, n_rst, n_dl, k, j, cyc, lim;

    watchdog_control_status #(.BASE_CYCLES(8)) u_watchdog_control_status (
        .sys_clk(sys_clk), .arst_n(arst_n), .sfr_wr(sfr_wr),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .instr_done(instr_done),
        .supply_monitor_event(supply_monitor_event),
        .lock_loss_event(lock_loss_event), .sfr_rdata(sfr_rdata),
        .wdt_irq(wdt_irq), .wdt_reset(wdt_reset),
        .download_reset(download_reset));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        n_irq += int'(wdt_irq === 1'b1);
        n_rst += int'(wdt_reset === 1'b1);
        n_dl += int'(download_reset === 1'b1);
    end

    task automatic chk(input string nm, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // all drivers start and end 1 ns after a rising edge
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt

    task automatic raw(input logic [7:0] d);
        sfr_wr = 1'b1;
        sfr_wdata = d;
        wt(1);
        sfr_wr = 1'b0;
    endtask : raw

    task automatic idn;
        instr_done = 1'b1;
        wt(1);
        instr_done = 1'b0;
    endtask : idn

    // unlock, end that instruction, then the real write
    task automatic pw(input logic [7:0] d);
        raw(8'h01);
        idn();
        raw(d);
        idn();
    endtask : pw

    function automatic logic [7:0] ctl(input logic [3:0] c, input logic r);
        return {c, r, 3'b010};
    endfunction : ctl

    task automatic final_report;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        {arst_n, sfr_wr, instr_done, sfr_wdata} = '0;
        {supply_monitor_event, lock_loss_event} = '0;
        sfr_addr = 8'hc0;
        void'($urandom(32'h0c001636));
        wt(4);
        arst_n = 1'b1;
        chk("reset value", 8'h02, sfr_rdata);
        wt(20);
        chk("auto timeout", 8'h01, 8'(n_rst));
        chk("after timeout", 8'h04, sfr_rdata);
        raw(8'hfa);
        wt(1);
        raw(8'h01);
        idn();
        wt(1);
        idn();
        raw(8'hfa);
        wt(2);
        chk("locked write", 8'h04, sfr_rdata);
        pw(8'h00);
        wt(2);
        chk("status clear", 8'h00, sfr_rdata);
        $display("register test done");
        repeat (3) begin
            p = 2'($urandom % 3);
            pw(ctl({2'b00, p}, 1'b1));
            k = n_irq;
            j = n_rst;
            cyc = 0;
            while (n_irq == k && cyc < 100) begin
                wt(1);
                cyc++;
            end
            // expiry lands 8 << p after the accepted write
            lim = int'(cyc inside {[(8 << p) - 2:(8 << p) + 4]});
            chk("period", 8'h01, 8'(lim));
            k = n_irq;
            repeat (5) pw(ctl({2'b00, p}, 1'b1));
            chk("serviced", 8'(k), 8'(n_irq));
            chk("no reset", 8'(j), 8'(n_rst));
        end
        $display("timeout test done");
        for (int i = 0; i < 2; i++) begin
            pw(8'h12);
            supply_monitor_event = (i == 0);
            lock_loss_event = (i == 1);
            wt(1);
            {supply_monitor_event, lock_loss_event} = '0;
            wt(3);
            chk("event disable", 8'h00, {7'h0, sfr_rdata[1]});
        end
        $display("event test done");
        for (int c = 8; c < 11; c++) begin
            k = n_rst;
            j = n_dl;
            pw(ctl(4'(c), 1'b0));
            wt(40);
            chk("forced reset", 8'(c < 10), 8'(n_rst - k));
            chk("download", 8'(c == 9), 8'(n_dl - j));
        end
        $display("code test done");
        // status set by a watchdog reset survives until the pin resets it
        pw(ctl(4'h8, 1'b0));
        wt(4);
        chk("forced status", 8'h84, sfr_rdata);
        arst_n = 1'b0;
        wt(2);
        chk("pin reset", 8'h02, sfr_rdata);
        arst_n = 1'b1;
        wt(1);
        chk("after release", 8'h02, sfr_rdata);
        $display("pin reset test done");
        final_report();
    end

    initial begin
        #20us;
        n_mismatch++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
